//--- chgcfg_regs.vh
`ifndef CHGCFG_REGS_VH
`define CHGCFG_REGS_VH
// Register offsets (command codes)
`define CC_IIN_LIMIT_TGT 8'h15
`define CC_VIN_FLOOR_TGT 8'h16
`define CC_ICHG_TGT 8'h1A
`define CC_VCHG_TGT 8'h1B
`define CC_CV_TIMEOUT 8'h1D
`define CC_CHG_TIMEOUT 8'h1E
`define CC_ABS_TIMEOUT 8'h2B
`define CC_EQ_TIMEOUT 8'h2D
`define CC_CHG_ELAPSED 8'h30
`define CC_CV_ELAPSED 8'h31
`define CC_ABS_ELAPSED 8'h32
`define CC_EQ_ELAPSED 8'h33
`define CC_ICHG_APPLIED 8'h44
`define CC_VCHG_APPLIED 8'h45
`define CC_IIN_APPLIED 8'h46
`define CC_STORAGE_ARM 8'h4F
// Reset values and the arming code
`define CC_IIN_LIMIT_RST 6'h3F
`define CC_VIN_FLOOR_RST 9'h0FF
`define CC_ICHG_RST 5'h1F
`define CC_VCHG_RST 6'h3F
`define CC_CV_TIMEOUT_RST 16'h3840
`define CC_CHG_TIMEOUT_RST 16'hFD20
`define CC_ABS_TIMEOUT_RST 16'h0384
`define CC_EQ_TIMEOUT_RST 16'h0E10
`define CC_ARM_VALUE 16'h534D
// Timer indices
`define CC_T_CHG 0
`define CC_T_CV 1
`define CC_T_ABS 2
`define CC_T_EQ 3
// Strap pin levels as reported by the three-level detector
`define CC_PIN_L 2'h0
`define CC_PIN_H 2'h1
`define CC_PIN_Z 2'h2
// Timing
`define CC_TICK_PERIOD_NS 1000000000
`define CC_CLK_PERIOD_NS 10
`define CC_TICK_CYCLES (`CC_TICK_PERIOD_NS / `CC_CLK_PERIOD_NS)
`endif

//--- chgcfg_top.v
// Function
// - Four 16-bit timers count whole seconds, span about 18.2 hours.
// - Each timer has read-only elapsed register and read/write timeout register.
// - Writing 0x534D to the arming register arms storage mode; others do not.
// - Once armed, the arming register cannot be changed by writes; only reset or a completed wake clears it.
// - Armed device enters storage mode only when input voltage falls below threshold.
// - Input returning above threshold starts the wake; completing it leaves storage mode and resets all registers.
// - Staying out of storage mode latches only after input and rail are ready.
// - In storage mode the cutoff gate output turns the external switch off.
// - Charge voltage target writes keep bits 4:0 for lithium, 5:0 for lead-acid; reset loads 0x3F for both.
// - Converter targets are read/write; applied values are read-only.
// - Three three-level straps set cell count, up to nine for lithium.
// - Cell straps decode per table; 12 cells only with HHH.
// - Lead-acid accepts only 3, 6 or 12 cells.
// - No per-cell monitoring; per-cell voltage is stack divided by count.
// - Two three-level straps select one of nine charging algorithms.
// - Chemistry straps decode per table, nine combinations.
`timescale 1ns/1ns
`default_nettype none
`include "chgcfg_regs.vh"
module chgcfg_top #(
  parameter [6:0] DEV_ADDR = 7'h68,
  parameter [31:0] TICK_CYCLES = `CC_TICK_CYCLES
) (
  input wire i_mclk,
  input wire i_rst_n,
  input wire i_scl,
  input wire i_sda,
  output reg o_sda_out,
  output reg o_sda_oe,
  input wire i_vin_above_thresh,
  input wire i_rail_ready,
  input wire [1:0] i_cell_count_sel_hi,
  input wire [1:0] i_cell_count_sel_mid,
  input wire [1:0] i_cell_count_sel_lo,
  input wire [1:0] i_chemistry_sel_hi,
  input wire [1:0] i_chemistry_sel_lo,
  input wire [3:0] i_phase_run,
  input wire [4:0] i_charge_current_applied,
  input wire [5:0] i_charge_voltage_applied,
  input wire [5:0] i_input_current_limit_applied,
  output reg [3:0] o_phase_expired,
  output reg [5:0] o_input_current_limit_target,
  output reg [8:0] o_input_voltage_floor_target,
  output reg [4:0] o_charge_current_target,
  output reg [5:0] o_charge_voltage_target,
  output reg o_sys_cutoff_gate,
  output reg o_storage_mode,
  output reg [3:0] o_cell_count,
  output reg o_cell_count_valid,
  output reg [3:0] o_chemistry,
  output reg o_lead_acid
);
  // ==========================================
  // Pin synchronisers
  // ==========================================
  // Three stages; a level counts once stages two and three agree
  reg [2:0] scl_sh, sda_sh, vin_sh, rail_sh;
  reg [2:0] strap_sh [0:9];
  reg scl_f, sda_f, scl_p, sda_p, vin_f, rail_f;
  reg [9:0] strap_f;
  wire [9:0] strap_raw = {i_cell_count_sel_hi, i_cell_count_sel_mid, i_cell_count_sel_lo,
    i_chemistry_sel_hi, i_chemistry_sel_lo};
  genvar g;
  generate
    for (g = 0; g < 10; g = g + 1) begin : g_strap
      always @(posedge i_mclk) begin
        strap_sh[g] <= {strap_sh[g][1:0], strap_raw[g]};
        if (strap_sh[g][1] == strap_sh[g][2]) begin
          strap_f[g] <= strap_sh[g][2];
        end
      end
    end
  endgenerate
  always @(posedge i_mclk) begin
    scl_sh <= {scl_sh[1:0], i_scl};
    sda_sh <= {sda_sh[1:0], i_sda};
    vin_sh <= {vin_sh[1:0], i_vin_above_thresh};
    rail_sh <= {rail_sh[1:0], i_rail_ready};
    if (!i_rst_n) begin
      scl_f <= 1'b1;
      sda_f <= 1'b1;
      scl_p <= 1'b1;
      sda_p <= 1'b1;
      vin_f <= 1'b1;
      rail_f <= 1'b0;
    end else begin
      if (scl_sh[1] == scl_sh[2]) scl_f <= scl_sh[2];
      if (sda_sh[1] == sda_sh[2]) sda_f <= sda_sh[2];
      if (vin_sh[1] == vin_sh[2]) vin_f <= vin_sh[2];
      if (rail_sh[1] == rail_sh[2]) rail_f <= rail_sh[2];
      scl_p <= scl_f;
      sda_p <= sda_f;
    end
  end
  wire scl_rise = scl_f & ~scl_p;
  wire scl_fall = ~scl_f & scl_p;
  wire bus_start = scl_f & scl_p & sda_p & ~sda_f;
  wire bus_stop = scl_f & scl_p & ~sda_p & sda_f;

  // ==========================================
  // Storage mode sequencer
  // ==========================================
  localparam [1:0] SM_RUN = 2'h0;
  localparam [1:0] SM_SHIP = 2'h1;
  localparam [1:0] SM_WAKE = 2'h2;
  reg [1:0] sm_state;
  reg [15:0] storage_arm;
  reg wake_clr;
  wire regs_rst = !i_rst_n || wake_clr;
  wire armed = (storage_arm == `CC_ARM_VALUE);
  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      sm_state <= SM_RUN;
      wake_clr <= 1'b0;
      o_sys_cutoff_gate <= 1'b0;
      o_storage_mode <= 1'b0;
    end else begin
      wake_clr <= 1'b0;
      case (sm_state)
        SM_RUN: begin
          if (armed && !vin_f) sm_state <= SM_SHIP;
        end
        SM_SHIP: begin
          if (vin_f) sm_state <= SM_WAKE;
        end
        SM_WAKE: begin
          if (!vin_f) begin
            sm_state <= SM_SHIP;
          end else if (rail_f) begin
            sm_state <= SM_RUN;
            wake_clr <= 1'b1;
          end
        end
        default: sm_state <= SM_RUN;
      endcase
      o_sys_cutoff_gate <= (sm_state != SM_RUN);
      o_storage_mode <= (sm_state != SM_RUN);
    end
  end

  // ==========================================
  // Strap decode
  // ==========================================
  // Straps are caught once after reset or a completed wake; a static board tie is assumed
  reg strap_done;
  reg [3:0] next_cells;
  reg next_cells_ok;
  reg [3:0] next_chem;
  always @* begin
    next_cells_ok = 1'b1;
    case (strap_f[9:4])
      {`CC_PIN_L, `CC_PIN_L, `CC_PIN_H}: next_cells = 4'h1;
      {`CC_PIN_L, `CC_PIN_H, `CC_PIN_L}: next_cells = 4'h2;
      {`CC_PIN_L, `CC_PIN_H, `CC_PIN_H}: next_cells = 4'h3;
      {`CC_PIN_L, `CC_PIN_L, `CC_PIN_Z}: next_cells = 4'h4;
      {`CC_PIN_L, `CC_PIN_Z, `CC_PIN_L}: next_cells = 4'h5;
      {`CC_PIN_L, `CC_PIN_H, `CC_PIN_Z}: next_cells = 4'h6;
      {`CC_PIN_L, `CC_PIN_Z, `CC_PIN_H}: next_cells = 4'h7;
      {`CC_PIN_L, `CC_PIN_Z, `CC_PIN_Z}: next_cells = 4'h8;
      {`CC_PIN_H, `CC_PIN_L, `CC_PIN_L}: next_cells = 4'h9;
      {`CC_PIN_H, `CC_PIN_H, `CC_PIN_H}: next_cells = 4'hC;
      default: begin
        next_cells = 4'h0;
        next_cells_ok = 1'b0;
      end
    endcase
    case (strap_f[3:0])
      {`CC_PIN_L, `CC_PIN_L}: next_chem = 4'h0;
      {`CC_PIN_H, `CC_PIN_H}: next_chem = 4'h1;
      {`CC_PIN_L, `CC_PIN_Z}: next_chem = 4'h2;
      {`CC_PIN_Z, `CC_PIN_L}: next_chem = 4'h3;
      {`CC_PIN_L, `CC_PIN_H}: next_chem = 4'h4;
      {`CC_PIN_H, `CC_PIN_Z}: next_chem = 4'h5;
      {`CC_PIN_Z, `CC_PIN_H}: next_chem = 4'h6;
      {`CC_PIN_Z, `CC_PIN_Z}: next_chem = 4'h7;
      {`CC_PIN_H, `CC_PIN_L}: next_chem = 4'h8;
      default: next_chem = 4'hF;
    endcase
  end
  wire next_lead = (next_chem == 4'h7) || (next_chem == 4'h8);
  reg [1:0] strap_wait;
  always @(posedge i_mclk) begin
    if (regs_rst) begin
      strap_done <= 1'b0;
      strap_wait <= 2'h0;
      o_cell_count <= 4'h0;
      o_cell_count_valid <= 1'b0;
      o_chemistry <= 4'hF;
      o_lead_acid <= 1'b0;
    end else if (!strap_done) begin
      // Wait for the synchronisers to fill before latching
      strap_wait <= strap_wait + 2'h1;
      if (strap_wait == 2'h3) begin
        strap_done <= 1'b1;
        o_chemistry <= next_chem;
        o_lead_acid <= next_lead;
        o_cell_count <= next_cells;
        o_cell_count_valid <= next_cells_ok && (next_chem != 4'hF) &&
          (next_lead ? (next_cells == 4'h3 || next_cells == 4'h6 || next_cells == 4'hC)
                     : (next_cells != 4'hC));
      end
    end
  end

  // ==========================================
  // Charge phase timers
  // ==========================================
  reg [31:0] tick_cnt;
  reg tick;
  reg [15:0] elapsed [0:3];
  reg [15:0] timeout [0:3];
  always @(posedge i_mclk) begin
    if (regs_rst) begin
      tick_cnt <= 32'h0;
      tick <= 1'b0;
    end else begin
      tick <= (tick_cnt == TICK_CYCLES - 32'h1);
      tick_cnt <= (tick_cnt == TICK_CYCLES - 32'h1) ? 32'h0 : tick_cnt + 32'h1;
    end
  end
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_timer
      always @(posedge i_mclk) begin
        if (regs_rst) begin
          elapsed[g] <= 16'h0;
          o_phase_expired[g] <= 1'b0;
        end else begin
          // one count per second, holds at full scale
          if (!i_phase_run[g]) begin
            elapsed[g] <= 16'h0;
          end else if (tick && elapsed[g] != 16'hFFFF) begin
            elapsed[g] <= elapsed[g] + 16'h1;
          end
          o_phase_expired[g] <= i_phase_run[g] && (elapsed[g] >= timeout[g]);
        end
      end
    end
  endgenerate

  // ==========================================
  // Serial port
  // ==========================================
  localparam [2:0] SP_IDLE = 3'h0;
  localparam [2:0] SP_ADDR = 3'h1;
  localparam [2:0] SP_CMD = 3'h2;
  localparam [2:0] SP_WLO = 3'h3;
  localparam [2:0] SP_WHI = 3'h4;
  localparam [2:0] SP_RLO = 3'h5;
  localparam [2:0] SP_RHI = 3'h6;
  localparam [2:0] SP_SKIP = 3'h7;
  reg [2:0] sp_state;
  reg [3:0] bit_cnt;
  reg [7:0] shreg, cmd, wlo, tx;
  reg [15:0] rdata;
  reg wr_en;
  reg [15:0] wdata;
  wire sp_rd = (sp_state == SP_RLO) || (sp_state == SP_RHI);
  always @* begin
    case (cmd)
      `CC_IIN_LIMIT_TGT: rdata = {10'h0, o_input_current_limit_target};
      `CC_VIN_FLOOR_TGT: rdata = {7'h0, o_input_voltage_floor_target};
      `CC_ICHG_TGT: rdata = {11'h0, o_charge_current_target};
      `CC_VCHG_TGT: rdata = {10'h0, o_charge_voltage_target};
      `CC_CV_TIMEOUT: rdata = timeout[`CC_T_CV];
      `CC_CHG_TIMEOUT: rdata = timeout[`CC_T_CHG];
      `CC_ABS_TIMEOUT: rdata = timeout[`CC_T_ABS];
      `CC_EQ_TIMEOUT: rdata = timeout[`CC_T_EQ];
      `CC_CHG_ELAPSED: rdata = elapsed[`CC_T_CHG];
      `CC_CV_ELAPSED: rdata = elapsed[`CC_T_CV];
      `CC_ABS_ELAPSED: rdata = elapsed[`CC_T_ABS];
      `CC_EQ_ELAPSED: rdata = elapsed[`CC_T_EQ];
      `CC_ICHG_APPLIED: rdata = {11'h0, i_charge_current_applied};
      `CC_VCHG_APPLIED: rdata = {10'h0, i_charge_voltage_applied};
      `CC_IIN_APPLIED: rdata = {10'h0, i_input_current_limit_applied};
      `CC_STORAGE_ARM: rdata = storage_arm;
      default: rdata = 16'h0;
    endcase
  end
  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      sp_state <= SP_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h0;
      cmd <= 8'h0;
      wlo <= 8'h0;
      tx <= 8'h0;
      wr_en <= 1'b0;
      wdata <= 16'h0;
      o_sda_out <= 1'b0;
      o_sda_oe <= 1'b0;
    end else begin
      wr_en <= 1'b0;
      if (bus_start) begin
        sp_state <= SP_ADDR;
        bit_cnt <= 4'h0;
        o_sda_oe <= 1'b0;
      end else if (bus_stop) begin
        sp_state <= SP_IDLE;
        o_sda_oe <= 1'b0;
      end else if (sp_state != SP_IDLE && scl_rise) begin
        shreg <= {shreg[6:0], sda_f};
        bit_cnt <= bit_cnt + 4'h1;
        // Controller answers each read byte; a nack ends the read.
        // The address ack rise is skipped: our own ack still holds the line there
        if (sp_rd && bit_cnt == 4'h8 && !o_sda_oe) begin
          if (sda_f) begin
            sp_state <= SP_IDLE;
          end else if (sp_state == SP_RLO) begin
            sp_state <= SP_RHI;
            tx <= rdata[15:8];
          end
        end
      end else if (sp_state != SP_IDLE && scl_fall) begin
        if (bit_cnt == 4'h9) begin
          bit_cnt <= 4'h0;
          o_sda_oe <= sp_rd & ~tx[7];
        end else if (bit_cnt < 4'h8) begin
          o_sda_oe <= sp_rd & ~tx[3'h7 - bit_cnt[2:0]];
        end else if (sp_rd) begin
          o_sda_oe <= 1'b0;
        end else begin
          o_sda_oe <= 1'b1;
          case (sp_state)
            SP_ADDR: begin
              if (shreg[7:1] != DEV_ADDR) begin
                o_sda_oe <= 1'b0;
                sp_state <= SP_IDLE;
              end else if (shreg[0]) begin
                sp_state <= SP_RLO;
                tx <= rdata[7:0];
              end else begin
                sp_state <= SP_CMD;
              end
            end
            SP_CMD: begin
              cmd <= shreg;
              sp_state <= SP_WLO;
            end
            SP_WLO: begin
              wlo <= shreg;
              sp_state <= SP_WHI;
            end
            SP_WHI: begin
              wdata <= {shreg, wlo};
              wr_en <= 1'b1;
              // Stay busy so the ack is released on the next fall
              sp_state <= SP_SKIP;
            end
            // Surplus write bytes are not acked
            SP_SKIP: o_sda_oe <= 1'b0;
            default: sp_state <= SP_IDLE;
          endcase
        end
      end
    end
  end

  // ==========================================
  // Register file
  // ==========================================
  always @(posedge i_mclk) begin
    if (regs_rst) begin
      o_input_current_limit_target <= `CC_IIN_LIMIT_RST;
      o_input_voltage_floor_target <= `CC_VIN_FLOOR_RST;
      o_charge_current_target <= `CC_ICHG_RST;
      o_charge_voltage_target <= `CC_VCHG_RST;
      timeout[`CC_T_CV] <= `CC_CV_TIMEOUT_RST;
      timeout[`CC_T_CHG] <= `CC_CHG_TIMEOUT_RST;
      timeout[`CC_T_ABS] <= `CC_ABS_TIMEOUT_RST;
      timeout[`CC_T_EQ] <= `CC_EQ_TIMEOUT_RST;
      storage_arm <= 16'h0;
    end else if (wr_en) begin
      // targets writable, applied and elapsed not
      case (cmd)
        `CC_IIN_LIMIT_TGT: o_input_current_limit_target <= wdata[5:0];
        `CC_VIN_FLOOR_TGT: o_input_voltage_floor_target <= wdata[8:0];
        `CC_ICHG_TGT: o_charge_current_target <= wdata[4:0];
        // bit 5 kept only for lead-acid
        `CC_VCHG_TGT: o_charge_voltage_target <= {wdata[5] & o_lead_acid, wdata[4:0]};
        `CC_CV_TIMEOUT: timeout[`CC_T_CV] <= wdata;
        `CC_CHG_TIMEOUT: timeout[`CC_T_CHG] <= wdata;
        `CC_ABS_TIMEOUT: timeout[`CC_T_ABS] <= wdata;
        `CC_EQ_TIMEOUT: timeout[`CC_T_EQ] <= wdata;
        `CC_STORAGE_ARM: begin
          if (!armed) storage_arm <= wdata;
        end
        default: ;
      endcase
    end
  end
endmodule
`default_nettype wire

//--- chgcfg_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module chgcfg_host_model #(
  parameter int HALF = 8,
  parameter logic [6:0] ADDR = 7'h68
) (
  input wire logic i_mclk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_oe
);
  initial begin
    o_scl = 1'b1;
    o_sda_oe = 1'b0;
  end
  task automatic hw(input int n);
    repeat (n) @(posedge i_mclk);
  endtask
  // ==========================================
  // Bit level; released SDA floats to the pull-up
  task automatic sbit(input logic b, output logic r);
    o_sda_oe <= !b;
    hw(HALF);
    o_scl <= 1'b1;
    hw(HALF);
    r = i_sda;
    o_scl <= 1'b0;
    hw(1);
  endtask
  task automatic start();
    o_sda_oe <= 1'b0;
    hw(HALF);
    o_scl <= 1'b1;
    hw(HALF);
    o_sda_oe <= 1'b1;
    hw(HALF);
    o_scl <= 1'b0;
    hw(1);
  endtask
  task automatic stop();
    o_sda_oe <= 1'b1;
    hw(HALF);
    o_scl <= 1'b1;
    hw(HALF);
    o_sda_oe <= 1'b0;
    hw(HALF);
  endtask
  task automatic wbyte(input logic [7:0] d, output logic a);
    logic r;
    for (int i = 7; i >= 0; i--) sbit(d[i], r);
    sbit(1'b1, r);
    a = !r;
  endtask
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      sbit(1'b1, r);
      d[i] = r;
    end
    sbit(last, r);
  endtask
  // ==========================================
  // Word transfers, low byte first
  // host word write
  task automatic wr_word(input logic [6:0] ad, input logic [7:0] c,
      input logic [15:0] d, output logic ok);
    logic a0, a1, a2, a3;
    start();
    wbyte({ad, 1'b0}, a0);
    wbyte(c, a1);
    wbyte(d[7:0], a2);
    wbyte(d[15:8], a3);
    stop();
    ok = a0 & a1 & a2 & a3;
  endtask
  task automatic rd_word(input logic [7:0] c, output logic [15:0] d, output logic ok);
    logic a0, a1, a2;
    logic [7:0] lo, hi;
    start();
    wbyte({ADDR, 1'b0}, a0);
    wbyte(c, a1);
    start();
    wbyte({ADDR, 1'b1}, a2);
    rbyte(1'b0, lo);
    rbyte(1'b1, hi);
    stop();
    d = {hi, lo};
    ok = a0 & a1 & a2;
  endtask
endmodule
`default_nettype wire

//--- chgcfg_top_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module chgcfg_top_asserts (
  input wire i_mclk,
  input wire i_rst_n,
  input wire i_vin_above_thresh,
  input wire i_rail_ready,
  input wire [3:0] i_phase_run,
  input wire [3:0] o_phase_expired,
  input wire [5:0] o_input_current_limit_target,
  input wire [4:0] o_charge_current_target,
  input wire o_sys_cutoff_gate,
  input wire o_storage_mode,
  input wire [3:0] o_cell_count,
  input wire o_cell_count_valid,
  input wire [3:0] o_chemistry,
  input wire o_lead_acid
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  // ==========================================
  // Timers and storage mode
  property p_exp_run;
    o_phase_expired != 4'h0 |-> (o_phase_expired & ~$past(i_phase_run)) == 4'h0;
  endproperty
  a_exp_run: assert property (p_exp_run) else $error("expiry while idle");
  property p_enter;
    $rose(o_storage_mode) |-> !i_vin_above_thresh;
  endproperty
  a_enter: assert property (p_enter) else $error("storage with input up");
  property p_exit;
    $fell(o_storage_mode) |-> i_rail_ready && i_vin_above_thresh;
  endproperty
  a_exit: assert property (p_exit) else $error("early wake commit");
  property p_wake;
    $fell(o_storage_mode) |-> ##[0:3]
      (o_charge_current_target == 5'h1F && o_input_current_limit_target == 6'h3F);
  endproperty
  a_wake: assert property (p_wake) else $error("no defaults on wake");
  property p_gate_on;
    o_storage_mode |-> o_sys_cutoff_gate;
  endproperty
  a_gate_on: assert property (p_gate_on) else $error("cutoff not driven");
  property p_gate_src;
    $rose(o_sys_cutoff_gate) |-> $rose(o_storage_mode);
  endproperty
  a_gate_src: assert property (p_gate_src) else $error("stray cutoff");
  // ==========================================
  // Strap decode
  property p_pba;
    o_lead_acid == (o_chemistry == 4'h7 || o_chemistry == 4'h8);
  endproperty
  a_pba: assert property (p_pba) else $error("lead-acid flag mismatch");
  property p_pba_cnt;
    o_cell_count_valid && o_lead_acid |-> o_cell_count inside {4'h3, 4'h6, 4'hC};
  endproperty
  a_pba_cnt: assert property (p_pba_cnt) else $error("bad lead-acid count");
  property p_li_cnt;
    o_cell_count_valid && !o_lead_acid |-> o_cell_count inside {[4'h1:4'h9]};
  endproperty
  a_li_cnt: assert property (p_li_cnt) else $error("bad lithium count");
endmodule
bind chgcfg_top chgcfg_top_asserts chk_u (.i_mclk, .i_rst_n, .i_vin_above_thresh,
  .i_rail_ready, .i_phase_run, .o_phase_expired, .o_input_current_limit_target,
  .o_charge_current_target, .o_sys_cutoff_gate, .o_storage_mode, .o_cell_count,
  .o_cell_count_valid, .o_chemistry, .o_lead_acid);
`default_nettype wire

//--- chgcfg_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "chgcfg_regs.vh"
module chgcfg_top_tb;
  logic i_mclk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_vin_above_thresh = 1'b1;
  logic i_rail_ready = 1'b1;
  logic [5:0] cel = 6'h01;
  logic [3:0] chm = 4'h0;
  logic [3:0] i_phase_run = 4'h0;
  logic [4:0] i_charge_current_applied = 5'h0A;
  logic [5:0] i_charge_voltage_applied = 6'h21;
  logic [5:0] i_input_current_limit_applied = 6'h15;
  wire scl, h_oe, o_sda_out, o_sda_oe;
  wire sda = !((o_sda_oe && !o_sda_out) || h_oe);
  logic [3:0] o_phase_expired, o_cell_count, o_chemistry;
  logic [5:0] o_input_current_limit_target, o_charge_voltage_target;
  logic [8:0] o_input_voltage_floor_target;
  logic [4:0] o_charge_current_target;
  logic o_sys_cutoff_gate, o_storage_mode, o_cell_count_valid, o_lead_acid;
  int error_cnt = 0;
  int num_checks = 0;
  int cyc = 0;
  chgcfg_top #(.TICK_CYCLES(20)) dut_u (.i_mclk, .i_rst_n, .i_scl(scl), .i_sda(sda),
    .o_sda_out, .o_sda_oe, .i_vin_above_thresh, .i_rail_ready,
    .i_cell_count_sel_hi(cel[5:4]), .i_cell_count_sel_mid(cel[3:2]),
    .i_cell_count_sel_lo(cel[1:0]), .i_chemistry_sel_hi(chm[3:2]),
    .i_chemistry_sel_lo(chm[1:0]), .i_phase_run, .i_charge_current_applied,
    .i_charge_voltage_applied, .i_input_current_limit_applied, .o_phase_expired,
    .o_input_current_limit_target, .o_input_voltage_floor_target,
    .o_charge_current_target, .o_charge_voltage_target, .o_sys_cutoff_gate,
    .o_storage_mode, .o_cell_count, .o_cell_count_valid, .o_chemistry, .o_lead_acid);
  chgcfg_host_model host_u (.i_mclk, .i_sda(sda), .o_scl(scl), .o_sda_oe(h_oe));
  always #5 i_mclk = ~i_mclk;
  // ==========================================
  // Reporting and bus helpers
  task test_done;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      error_cnt++;
      $display("[FAIL] %0t timeout", $time);
      test_done;
    end
  end
  task chk(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task wait_n(input int n);
    repeat (n) @(posedge i_mclk);
  endtask
  task do_reset;
    i_rst_n <= 1'b0;
    wait_n(10);
    i_rst_n <= 1'b1;
    wait_n(20);
  endtask
  task wr(input logic [7:0] c, input logic [15:0] d);
    logic ok;
    host_u.wr_word(7'h68, c, d, ok);
    chk(16'(ok), 16'h0001);
  endtask
  task rd(input logic [7:0] c, output logic [15:0] d);
    logic ok;
    host_u.rd_word(c, d, ok);
    chk(16'(ok), 16'h0001);
  endtask
  task rdc(input logic [7:0] c, input logic [15:0] e);
    logic [15:0] d;
    rd(c, d);
    chk(d, e);
  endtask
  // ==========================================
  // Scenarios
  task t_straps;
    logic [9:0] ct [13] = '{10'h000, 10'h011, 10'h042, 10'h053, 10'h024, 10'h085,
      10'h066, 10'h097, 10'h0A8, 10'h109, 10'h110, 10'h140, 10'h15C};
    logic [7:0] ch [9] = '{8'h00, 8'h51, 8'h22, 8'h83, 8'h14, 8'h65, 8'h96, 8'hA7, 8'h48};
    logic [6:0] pb [5] = '{7'h14, 7'h0D, 7'h2B, 7'h0B, 7'h02};
    logic [3:0] n;
    for (int i = 0; i < 13; i++) begin
      cel <= ct[i][9:4];
      do_reset;
      n = ct[i][3:0];
      chk(16'(o_cell_count), 16'(n));
      chk(16'(o_cell_count_valid), 16'(n != 4'h0 && n < 4'hA));
    end
    cel <= 6'h05;
    for (int i = 0; i < 9; i++) begin
      chm <= ch[i][7:4];
      do_reset;
      chk(16'(o_chemistry), 16'(ch[i][3:0]));
      chk(16'(o_lead_acid), 16'(ch[i][3:0] > 4'h6));
      chk(16'(o_cell_count_valid), 16'h0001);
    end
    for (int i = 0; i < 5; i++) begin
      cel <= pb[i][6:1];
      do_reset;
      chk(16'(o_cell_count_valid), 16'(pb[i][0]));
    end
    wr(8'h1B, 16'h003F);
    rdc(8'h1B, 16'h003F);
    cel <= 6'h01;
    chm <= 4'h0;
    do_reset;
  endtask
  task t_defaults;
    logic [7:0] c [8] = '{8'h15, 8'h16, 8'h1A, 8'h1B, 8'h1D, 8'h1E, 8'h2B, 8'h2D};
    logic [15:0] e [8] = '{16'h003F, 16'h00FF, 16'h001F, 16'h003F, `CC_CV_TIMEOUT_RST,
      `CC_CHG_TIMEOUT_RST, `CC_ABS_TIMEOUT_RST, `CC_EQ_TIMEOUT_RST};
    for (int i = 0; i < 8; i++) rdc(c[i], e[i]);
    chk(16'(o_input_voltage_floor_target), 16'h00FF);
  endtask
  task t_targets;
    logic ok;
    wr(8'h15, 16'h002A);
    chk(16'(o_input_current_limit_target), 16'h002A);
    wr(8'h16, 16'h0123);
    rdc(8'h16, 16'h0123);
    wr(8'h1A, 16'h0005);
    wr(8'h1B, 16'h003F);
    rdc(8'h1B, 16'h001F);
    wr(8'h44, 16'h0000);
    rdc(8'h44, 16'h000A);
    rdc(8'h45, 16'h0021);
    rdc(8'h46, 16'h0015);
    host_u.wr_word(7'h69, 8'h1A, 16'h0009, ok);
    chk(16'(ok), 16'h0000);
    chk(16'(o_charge_current_target), 16'h0005);
  endtask
  task t_timers;
    logic [7:0] to [4] = '{8'h1E, 8'h1D, 8'h2B, 8'h2D};
    logic [15:0] d;
    for (int i = 0; i < 4; i++) wr(to[i], 16'h0003);
    i_phase_run <= 4'hF;
    wait_n(30);
    chk(16'(o_phase_expired), 16'h0000);
    wait_n(35);
    chk(16'(o_phase_expired), 16'h000F);
    wr(8'h31, 16'hFFFF);
    rd(8'h31, d);
    chk(16'(d >= 16'h0003 && d < 16'h0100), 16'h0001);
    i_phase_run <= 4'h0;
    wait_n(3);
    chk(16'(o_phase_expired), 16'h0000);
    rdc(8'h30, 16'h0000);
  endtask
  task t_arm;
    wr(`CC_STORAGE_ARM, 16'h1234);
    rdc(`CC_STORAGE_ARM, 16'h1234);
    i_vin_above_thresh <= 1'b0;
    wait_n(20);
    chk(16'(o_storage_mode), 16'h0000);
    i_vin_above_thresh <= 1'b1;
    wait_n(10);
    wr(`CC_STORAGE_ARM, 16'h534D);
    wr(`CC_STORAGE_ARM, 16'h0000);
    rdc(`CC_STORAGE_ARM, 16'h534D);
    chk(16'(o_storage_mode), 16'h0000);
    i_rail_ready <= 1'b0;
    i_vin_above_thresh <= 1'b0;
    wait_n(10);
    chk(16'({o_storage_mode, o_sys_cutoff_gate}), 16'h0003);
    i_vin_above_thresh <= 1'b1;
    wait_n(30);
    chk(16'(o_storage_mode), 16'h0001);
    i_rail_ready <= 1'b1;
    wait_n(10);
    chk(16'({o_storage_mode, o_sys_cutoff_gate}), 16'h0000);
    rdc(8'h15, 16'h003F);
    rdc(8'h1D, `CC_CV_TIMEOUT_RST);
    rdc(`CC_STORAGE_ARM, 16'h0000);
  endtask
  initial begin
    do_reset;
    t_straps;
    t_defaults;
    t_targets;
    t_timers;
    t_arm;
    test_done;
  end
endmodule
`default_nettype wire
